//--- tb/rcb_radio_model.sv
// Radio state, converter sample and supply comparator model
`timescale 1ns/1ps
module rcb_radio_model
  import rcb_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       strobeWr,
  input  wire logic [7:0] strobeData,
  input  wire logic [7:0] level,
  input  wire logic [2:0] regiLevel,
  input  wire logic       convRun,
  output logic      [2:0] rfState,
  output logic      [7:0] convSample,
  output logic      [3:0] supplyCompare
);
  // Strobe command picks the state; 0xC0 enters receive
  always_ff @(posedge clk or posedge rst)
    if (rst)
      rfState <= 3'h2;
    else if (strobeWr && strobeData[7])
      rfState <= strobeData[6:4];

  // Idle converter output changes every cycle
  always_ff @(posedge clk or posedge rst)
    if (rst)
      convSample <= 8'h00;
    else if (convRun)
      convSample <= level;
    else
      convSample <= ~convSample;

  // Comparator bit n high when regulator is above level n
  assign supplyCompare = {regiLevel > 3'h3, regiLevel > 3'h2,
                          regiLevel > 3'h1, regiLevel > 3'h0};
endmodule

//--- tb/rcb_top_chk.sv
// Port-level assertions for the strength, carrier and supply block
`timescale 1ns/1ps
module rcb_top_chk
  import rcb_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic [2:0]  rfState,
  input wire logic [7:0]  convSample,
  input wire logic [3:0]  supplyCompare,
  input wire logic [3:0]  pin2FunctionSelect,
  input wire logic        convRun,
  input wire logic        generalPinTwo,
  input wire logic        generalPinTwoOeN
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Bus requests taken by the slave
  sequence seqRd;
    hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
  endsequence
  sequence seqWr;
    hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
  endsequence

  AST_READ_WAIT: assert property (
    seqRd |=> !hreadyout ##1 hreadyout)
    else $error("read data phase timing wrong");
  AST_WRITE_NOWAIT: assert property (seqWr |=> hreadyout)
    else $error("write data phase stalled");
  AST_RESP_OKAY: assert property (hresp == HRESP_OKAY)
    else $error("response not okay");
  AST_RDATA_BYTE: assert property (hrdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  AST_RUN_ONLY_RX: assert property (rfState != RF_RX |-> !convRun)
    else $error("converter runs outside receive");
  AST_PIN_UNROUTED: assert property (
    !$past(rst) && $past(pin2FunctionSelect) != PIN2_CARRIER
    |-> !generalPinTwo && generalPinTwoOeN)
    else $error("pin two driven while not routed");
  AST_PIN_ROUTED: assert property (
    !$past(rst) && $past(pin2FunctionSelect) == PIN2_CARRIER
    |-> !generalPinTwoOeN)
    else $error("pin two not driven while routed");
  AST_PIN_CAUSE: assert property (
    $changed(generalPinTwo)
    && $past(pin2FunctionSelect) == $past(pin2FunctionSelect, 2)
    |-> $past(rfState, 2) == RF_RX || $past(rfState, 3) == RF_RX)
    else $error("carrier pin moved outside receive");
endmodule

//--- tb/testbench.sv
// Self-checking bench for the strength, carrier and supply block
`timescale 1ns/1ps
module testbench;
  import rcb_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [3:0]  pin2FunctionSelect = 4'h0;
  logic        strobeWr = 1'b0;
  logic [7:0]  strobeData = 8'h0;
  logic [7:0]  level = 8'h0;
  logic [2:0]  regiLevel = 3'h0;
  logic        hreadyout, hresp, convRun, generalPinTwo, generalPinTwoOeN;
  logic        expPin, prevFlag;
  logic [31:0] hrdata, rd, rnd;
  logic [2:0]  rfState;
  logic [3:0]  supplyCompare;
  logic [7:0]  convSample, thr, hy, lv2;
  logic [7:0]  lvTab [5];
  int          failCount = 0;
  int          samplesChecked = 0;
  int          cycles = 0;
  int          seed = 32'hFDCB921F;

  rcb_top dut_u (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .rfState(rfState), .convSample(convSample),
    .supplyCompare(supplyCompare), .pin2FunctionSelect(pin2FunctionSelect),
    .convRun(convRun), .generalPinTwo(generalPinTwo),
    .generalPinTwoOeN(generalPinTwoOeN));

  rcb_radio_model model_u (.clk(clk), .rst(rst), .strobeWr(strobeWr),
    .strobeData(strobeData), .level(level), .regiLevel(regiLevel),
    .convRun(convRun), .rfState(rfState), .convSample(convSample),
    .supplyCompare(supplyCompare));

  // Clock and hang guard
  initial forever #10 clk = ~clk;
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      failCount = failCount + 1;
      finishTest();
    end
  end

  // ****************************************************************
  // Tasks and expectations
  // ****************************************************************
  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] seen);
    samplesChecked++;
    if (seen !== exp)
    begin
      failCount++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finishTest();
    $display("checks %0d mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // One single transfer, held until hready is seen high
  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [7:0] d, output logic [31:0] q);
    logic ok;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do
    begin
      @(negedge clk);
      ok = hreadyout;
      @(posedge clk);
    end while (ok !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    do
    begin
      @(negedge clk);
      ok = hreadyout;
      q = hrdata;
      @(posedge clk);
    end while (ok !== 1'b1);
  endtask

  task automatic strobe(input logic [7:0] c);
    strobeWr <= 1'b1;
    strobeData <= c;
    @(posedge clk);
    strobeWr <= 1'b0;
  endtask

  function automatic logic nextPin(input logic p, input logic [7:0] r,
                                   input logic [7:0] t, input logic [7:0] h);
    if (r >= t)
      return 1'b0;
    if (t >= h && r <= t - h)
      return 1'b1;
    return p;
  endfunction

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    hsel <= 1'b1;
    @(posedge clk);
    // Reset values, unmapped and write-only places
    bus(1'b1, 32'h00002100, 8'hFF, rd);
    bus(1'b1, ADDR_RESULT, 8'h55, rd);
    bus(1'b0, ADDR_MODE, 8'h00, rd);
    check("mode", 32'h00, rd);
    bus(1'b0, ADDR_RESULT, 8'h00, rd);
    check("result", 32'h00, rd);
    bus(1'b0, ADDR_CONV, 8'h00, rd);
    check("conv ctrl", 32'h00, rd);
    bus(1'b0, 32'h00002100, 8'h00, rd);
    check("unmapped", 32'h00, rd);
    check("pin oe", 1'b1, generalPinTwoOeN);
    $display("reset test done");
    // Eight-sample averaging, repeated, then held
    rnd = $random(seed);
    level <= rnd[7:0];
    bus(1'b1, ADDR_CONV, 8'h42, rd);
    bus(1'b1, ADDR_MODE, 8'h40, rd);
    strobe(8'hC0);
    repeat (2) @(posedge clk);
    check("run", 1'b1, convRun);
    repeat (1850) @(posedge clk);
    bus(1'b0, ADDR_RESULT, 8'h00, rd);
    check("early avg", 32'h00, rd);
    repeat (300) @(posedge clk);
    bus(1'b0, ADDR_RESULT, 8'h00, rd);
    check("avg", {24'h0, rnd[7:0]}, rd);
    lv2 = rnd[15:8];
    level <= lv2;
    repeat (5000) @(posedge clk);
    bus(1'b0, ADDR_RESULT, 8'h00, rd);
    check("avg again", {24'h0, lv2}, rd);
    strobe(8'hA0);
    level <= ~lv2;
    bus(1'b1, ADDR_CONV, 8'h46, rd);
    strobe(8'hC0);
    repeat (4800) @(posedge clk);
    check("ext run", 1'b0, convRun);
    bus(1'b0, ADDR_RESULT, 8'h00, rd);
    check("held", {24'h0, lv2}, rd);
    $display("average test done");
    // Carrier detect with both hysteresis widths
    thr = 8'h20 + {1'b0, rnd[22:16]};
    bus(1'b1, ADDR_RESULT, thr, rd);
    bus(1'b1, ADDR_CONV, 8'hC2, rd);
    pin2FunctionSelect <= PIN2_CARRIER;
    expPin = 1'b0;
    for (int h = 0; h < 2; h++)
    begin
      hy = h[0] ? 8'h0C : 8'h06;
      lvTab = '{thr + 8'h01, thr - hy + 8'h01, thr - hy, thr - 8'h01, thr};
      bus(1'b1, ADDR_CONV, {7'h61, h[0]}, rd);
      for (int k = 0; k < 5; k++)
      begin
        level <= lvTab[k];
        repeat (300) @(posedge clk);
        expPin = nextPin(expPin, lvTab[k], thr, hy);
        check("carrier pin", expPin, generalPinTwo);
        bus(1'b0, ADDR_RESULT, 8'h00, rd);
        check("single", {24'h0, lvTab[k]}, rd);
      end
    end
    strobe(8'hA0);
    level <= thr - 8'h40;
    repeat (600) @(posedge clk);
    check("pin held", expPin, generalPinTwo);
    pin2FunctionSelect <= 4'h0;
    repeat (2) @(posedge clk);
    check("pin off", 2'b01, {generalPinTwo, generalPinTwoOeN});
    $display("carrier test done");
    // Supply detection at every level, radio in standby
    prevFlag = 1'b0;
    for (int s = 0; s < 4; s++)
    begin
      rnd = $random(seed);
      regiLevel <= {1'b0, rnd[1:0]} + {2'b00, rnd[2]};
      bus(1'b1, ADDR_SUPPLY, {4'h0, s[1:0], 2'h1}, rd);
      bus(1'b0, ADDR_SUPPLY, 8'h00, rd);
      check("flag busy", {31'h0, prevFlag}, rd);
      repeat (260) @(posedge clk);
      prevFlag = ({1'b0, rnd[1:0]} + {2'b00, rnd[2]}) > s[2:0];
      bus(1'b0, ADDR_SUPPLY, 8'h00, rd);
      check("flag", {31'h0, prevFlag}, rd);
    end
    $display("supply test done");
    finishTest();
  end
endmodule

bind rcb_top rcb_top_chk chk_u (.clk(clk), .rst(rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .rfState(rfState),
  .convSample(convSample), .supplyCompare(supplyCompare),
  .pin2FunctionSelect(pin2FunctionSelect), .convRun(convRun),
  .generalPinTwo(generalPinTwo), .generalPinTwoOeN(generalPinTwoOeN));

//--- verilog/rcb_hyst_cmp.sv
// Carrier threshold comparison with hysteresis
`timescale 1ns/1ps
module rcb_hyst_cmp
  import rcb_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  rcb_meas_if.cmp   meas
);
  logic [7:0] hyst;
  logic [8:0] lowEdge;

  // Hysteresis width and lower edge, guarded against underflow
  assign hyst    = meas.hystWide ? HYST_WIDE : HYST_NARROW; // RULE14
  assign lowEdge = {1'b0, meas.threshold} - {1'b0, hyst};

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      meas.carrierFlag <= 1'b0;
    else if (meas.cmpUpdate)
    begin
      if (meas.result >= meas.threshold)
        meas.carrierFlag <= 1'b0; // RULE13
      else if (!lowEdge[8] && meas.result <= lowEdge[7:0])
        meas.carrierFlag <= 1'b1; // RULE13
    end
  end
endmodule

//--- verilog/rcb_meas_if.sv
// Bundle between the register top, the sampler and the carrier comparator
`timescale 1ns/1ps
interface rcb_meas_if;
  logic       run;
  logic       singleMode;
  logic [7:0] sample;
  logic [7:0] result;
  logic       resultStrobe;
  logic       cmpUpdate;
  logic [7:0] threshold;
  logic       hystWide;
  logic       carrierFlag;

  modport top     (output run, singleMode, sample, cmpUpdate, threshold,
                   hystWide, input result, resultStrobe, carrierFlag);
  modport sampler (input run, singleMode, sample,
                   output result, resultStrobe);
  modport cmp     (input result, cmpUpdate, threshold, hystWide,
                   output carrierFlag);
endinterface

//--- verilog/rcb_pkg.sv
// Constants and types for the strength, carrier and supply detect block
// Function
// RULE1: Converter clock is 4 MHz; a conversion lasts 20 converter clocks.
// RULE2: Convert only in receive with external select 0 and strength select 1.
// RULE3: In receive with auto strength on, keep averaging eight conversions.
// RULE4: Each strength result reads back in bits 7..0 of the result register.
// RULE5: After receive ends, the last strength result is held for reading.
// RULE6: Software sets strength select 1 and clock select 0 before receive.
// RULE7: Software sets auto strength enable before the receive command.
// RULE8: In direct mode software leaves receive within 40 us of measuring.
// RULE9: Software waits 140 us after receive before reading background power.
// RULE10: In carrier mode strength refreshes every 5 us, single conversions.
// RULE11: Writing result address loads threshold; reading returns result.
// RULE12: Pin two select 0010 routes the carrier flag onto general pin two.
// RULE13: Pin low at or above threshold, high at or below it minus hysteresis.
// RULE14: Mode field 11 gives hysteresis 6 when select is 0, 12 when 1.
// RULE15: Software waits 100 us after receive before sampling the carrier pin.
// RULE16: Supply threshold field picks 2.0, 2.2, 2.4 or 2.6 volt level.
// RULE17: Supply flag high when regulator input is above level, else low.
// RULE18: Writing supply enable starts detection; it self-clears 5 us later.
// RULE19: Software puts radio in standby or PLL before enabling supply detect.
// RULE20: Software enters receive by writing 0xC0 to the strobe register.
// RULE21: Outside receive, carrier flag and strength result hold their values.
package rcb_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ        = 50;
  localparam int CONV_MHZ       = 4;
  localparam int CONV_TICKS     = 20;
  localparam int AVG_SHIFT      = 3;
  localparam int SUPPLY_TIME_US = 5;
  localparam int SUPPLY_CYCLES  = SUPPLY_TIME_US * CLK_MHZ;

  // ****************************************************************
  // Register indices and byte addresses
  // ****************************************************************
  localparam logic [15:0] IDX_MODE   = 16'h0802;
  localparam logic [15:0] IDX_RESULT = 16'h0821;
  localparam logic [15:0] IDX_CONV   = 16'h0822;
  localparam logic [15:0] IDX_SUPPLY = 16'h082C;
  localparam logic [31:0] ADDR_MODE   = {14'h0000, IDX_MODE, 2'h0};
  localparam logic [31:0] ADDR_RESULT = {14'h0000, IDX_RESULT, 2'h0};
  localparam logic [31:0] ADDR_CONV   = {14'h0000, IDX_CONV, 2'h0};
  localparam logic [31:0] ADDR_SUPPLY = {14'h0000, IDX_SUPPLY, 2'h0};

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int MODE_AUTO_BIT    = 6;
  localparam int MODE_CARRIER_BIT = 4;
  localparam int CC_MODE_HI       = 7;
  localparam int CC_MODE_LO       = 6;
  localparam int CC_CLKSEL_BIT    = 4;
  localparam int CC_EXT_BIT       = 2;
  localparam int CC_RSS_BIT       = 1;
  localparam int CC_HYST_BIT      = 0;
  localparam int SD_SEL_HI        = 3;
  localparam int SD_SEL_LO        = 2;
  localparam int SD_ENABLE_BIT    = 0;
  localparam int SD_FLAG_BIT      = 0;

  // ****************************************************************
  // Reset values and encodings
  // ****************************************************************
  localparam logic [7:0] MODE_RESET   = 8'h00;
  localparam logic [7:0] THRESH_RESET = 8'h91;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [7:0] CONV_RESET   = 8'h53;
  localparam logic [7:0] SUPPLY_RESET = 8'h06;
  localparam logic [1:0] CARRIER_MODE = 2'h3;
  localparam logic [7:0] HYST_NARROW  = 8'h06;
  localparam logic [7:0] HYST_WIDE    = 8'h0C;
  localparam logic [3:0] PIN2_CARRIER = 4'h2;
  localparam logic [2:0] RF_RX        = 3'h4;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY   = 1'h0;

  // Supply detection sequence
  typedef enum logic [0:0] {SD_IDLE, SD_WAIT} rcb_sd_state_t;

endpackage

//--- verilog/rcb_sampler.sv
// Converter clock divider, conversion timer and eight-sample averager
`timescale 1ns/1ps
module rcb_sampler
  import rcb_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  rcb_meas_if.sampler meas
);
  logic [5:0]  accFf;
  logic [5:0]  nxt_acc;
  logic        convTick;
  logic [4:0]  tickCntFf;
  logic        convDone;
  logic [10:0] sumFf;
  logic [10:0] nxt_sum;
  logic [2:0]  avgCntFf;

  // Fractional divider: 4 MHz enable from 50 MHz on average
  always_comb
  begin
    nxt_acc  = accFf + 6'(CONV_MHZ);
    convTick = (nxt_acc >= 6'(CLK_MHZ));
    if (convTick)
    begin
      nxt_acc = nxt_acc - 6'(CLK_MHZ);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      accFf <= 6'h00;
    else
      accFf <= nxt_acc; // RULE1
  end

  // Conversion timer, restarted while idle
  assign convDone = convTick && (tickCntFf == 5'(CONV_TICKS - 1));

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      tickCntFf <= 5'h00;
    else if (!meas.run)
      tickCntFf <= 5'h00;
    else if (convDone)
      tickCntFf <= 5'h00; // RULE1
    else if (convTick)
      tickCntFf <= tickCntFf + 5'h01;
  end

  // Accumulate samples; single mode bypasses the average
  assign nxt_sum = sumFf + {3'h0, meas.sample};

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sumFf    <= 11'h000;
      avgCntFf <= 3'h0;
    end
    else if (!meas.run || meas.singleMode)
    begin
      sumFf    <= 11'h000;
      avgCntFf <= 3'h0;
    end
    else if (convDone)
    begin
      avgCntFf <= avgCntFf + 3'h1; // RULE3
      sumFf    <= (avgCntFf == 3'h7) ? 11'h000 : nxt_sum;
    end
  end

  // Result register holds its value when not running
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meas.result       <= RESULT_RESET;
      meas.resultStrobe <= 1'b0;
    end
    else
    begin
      meas.resultStrobe <= 1'b0;
      if (meas.run && convDone && meas.singleMode) // RULE5
      begin
        meas.result       <= meas.sample; // RULE10
        meas.resultStrobe <= 1'b1;
      end
      else if (meas.run && convDone && avgCntFf == 3'h7)
      begin
        meas.result       <= 8'(nxt_sum >> AVG_SHIFT); // RULE3
        meas.resultStrobe <= 1'b1;
      end
    end
  end
endmodule

//--- verilog/rcb_top.sv
// Strength, carrier and supply detect block with AHB-Lite register slave
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
module rcb_top
  import rcb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic [2:0]  rfState,
  input  wire logic [7:0]  convSample,
  input  wire logic [3:0]  supplyCompare,
  input  wire logic [3:0]  pin2FunctionSelect,
  output logic             convRun,
  output logic             generalPinTwo,
  output logic             generalPinTwoOeN
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic          inRx;
  logic          addrPhase;
  logic          wrPendFf;
  logic [31:0]   wrAddrFf;
  logic          rdPendFf;
  logic [31:0]   rdAddrFf;
  logic          wrMode;
  logic          wrResult;
  logic          wrConv;
  logic          wrSupply;
  logic [7:0]    modeFf;
  logic [7:0]    thresholdFf;
  logic [7:0]    convCtrlFf;
  logic [7:0]    supplyCfgFf;
  logic          supplyFlagFf;
  logic          supplyEnable;
  rcb_sd_state_t sdStateFf;
  rcb_sd_state_t nxt_sdState;
  logic [7:0]    sdCntFf;
  logic          sdDone;
  logic [7:0]    readValue;
  logic          carrierMode;
  logic          routeCarrier;

  rcb_meas_if meas ();

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************

  // Valid transfer in its address phase
  assign addrPhase = hsel && hready && htrans == HTRANS_NONSEQ;

  // Write data phase tracking
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wrPendFf <= 1'b0;
      wrAddrFf <= 32'h0000_0000;
    end
    else if (hready)
    begin
      wrPendFf <= addrPhase && hwrite;
      wrAddrFf <= haddr;
    end
  end

  // Read takes one wait state so pending writes land first
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdPendFf <= 1'b0;
      rdAddrFf <= 32'h0000_0000;
    end
    else if (rdPendFf)
      rdPendFf <= 1'b0;
    else if (addrPhase && !hwrite)
    begin
      rdPendFf <= 1'b1;
      rdAddrFf <= haddr;
    end
  end

  assign hreadyout = !rdPendFf;
  assign hresp     = HRESP_OKAY;

  // Write strobes per register
  assign wrMode   = wrPendFf && wrAddrFf == ADDR_MODE;
  assign wrResult = wrPendFf && wrAddrFf == ADDR_RESULT;
  assign wrConv   = wrPendFf && wrAddrFf == ADDR_CONV;
  assign wrSupply = wrPendFf && wrAddrFf == ADDR_SUPPLY;

  // Read multiplexer; unmapped and write-only read as zero
  always_comb
  begin
    readValue = 8'h00;
    case (rdAddrFf)
      ADDR_MODE:
      begin
        readValue = modeFf;
        readValue[MODE_CARRIER_BIT] = meas.carrierFlag;
      end
      ADDR_RESULT:
        readValue = meas.result; // RULE4 RULE11
      ADDR_SUPPLY:
        readValue[SD_FLAG_BIT] = supplyFlagFf;
      default:
        readValue = 8'h00;
    endcase
  end

  // Read data register loaded in the wait state
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      hrdata <= 32'h0000_0000;
    else if (rdPendFf)
      hrdata <= {24'h00_0000, readValue};
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************

  // Mode control; carrier bit on write is a stored filter option
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      modeFf <= MODE_RESET;
    else if (wrMode)
      modeFf <= hwdata[7:0];
  end

  // Threshold shares the result address on the write side
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      thresholdFf <= THRESH_RESET;
    else if (wrResult)
      thresholdFf <= hwdata[7:0]; // RULE11
  end

  // Converter control, write only
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      convCtrlFf <= CONV_RESET;
    else if (wrConv)
      convCtrlFf <= hwdata[7:0];
  end

  // ****************************************************************
  // Measurement control
  // ****************************************************************

  // Receive only; no conversion in standby or other states
  assign inRx = rfState == RF_RX;

  // Run with external select 0, strength select 1, auto enabled
  assign meas.run = inRx
                    && !convCtrlFf[CC_EXT_BIT]
                    && convCtrlFf[CC_RSS_BIT]
                    && modeFf[MODE_AUTO_BIT]; // RULE2 RULE3 RULE21
  assign convRun  = meas.run;

  // Mode field 11 selects single-conversion carrier detection
  assign carrierMode     = convCtrlFf[CC_MODE_HI:CC_MODE_LO]
                           == CARRIER_MODE; // RULE10
  assign meas.singleMode = carrierMode;
  assign meas.sample     = convSample;

  // Comparator updates only on fresh results in receive
  assign meas.cmpUpdate = meas.resultStrobe && carrierMode
                          && inRx; // RULE21
  assign meas.threshold = thresholdFf;
  assign meas.hystWide  = convCtrlFf[CC_HYST_BIT]; // RULE14

  rcb_sampler u_sampler
  (
    .clk  (clk),
    .rst  (rst),
    .meas (meas)
  );

  rcb_hyst_cmp u_cmp
  (
    .clk  (clk),
    .rst  (rst),
    .meas (meas)
  );

  // ****************************************************************
  // General pin two routing
  // ****************************************************************

  // Carrier flag drives pin two when its select picks carrier
  assign routeCarrier = pin2FunctionSelect == PIN2_CARRIER;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      generalPinTwo    <= 1'b0;
      generalPinTwoOeN <= 1'b1;
    end
    else
    begin
      generalPinTwo    <= routeCarrier && meas.carrierFlag; // RULE12
      generalPinTwoOeN <= !routeCarrier; // RULE12
    end
  end

  // ****************************************************************
  // Supply detection
  // ****************************************************************

  // Configuration bits; the enable bit lives in the sequencer
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      supplyCfgFf <= SUPPLY_RESET;
    else if (wrSupply)
      supplyCfgFf <= hwdata[7:0];
  end

  assign supplyEnable = sdStateFf == SD_WAIT;
  assign sdDone       = sdCntFf == 8'(SUPPLY_CYCLES - 1);

  // Sequencer next state
  always_comb
  begin
    nxt_sdState = sdStateFf;
    case (sdStateFf)
      SD_IDLE:
        if (wrSupply && hwdata[SD_ENABLE_BIT])
          nxt_sdState = SD_WAIT; // RULE18
      SD_WAIT:
        if (sdDone)
          nxt_sdState = SD_IDLE; // RULE18
      default:
        nxt_sdState = SD_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sdStateFf <= SD_IDLE;
    else
      sdStateFf <= nxt_sdState;
  end

  // Detection timer
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sdCntFf <= 8'h00;
    else if (!supplyEnable || sdDone)
      sdCntFf <= 8'h00;
    else
      sdCntFf <= sdCntFf + 8'h01;
  end

  // Flag latched from the comparator of the selected level
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      supplyFlagFf <= 1'b0;
    else if (supplyEnable && sdDone)
      supplyFlagFf <=
        supplyCompare[supplyCfgFf[SD_SEL_HI:SD_SEL_LO]]; // RULE16 RULE17
  end

endmodule
